/* common/ascii_rx_consts.vh */
// constants shared by the ascii string receiver
// Behaviour
// - fixed mode: ends after 1..128 programmed bytes
// - fixed complete holds until enable drops
// - inter-character gap over limit sets flag
// - after inter-character timeout nothing more stored
// - first character late sets first timeout flag
// - timeout flags clear when enable removed
// - zero millisecond setting disables that timeout
// - optional swap of bytes in each word
// - busy while string characters are arriving
// - variable complete on terminator, clears on disable
// - terminator is one or two bytes
// - variable overflow past max length 1..128
// - count in first word, data follows
// - port active and comm error flags
// - invalid parameter and cannot execute flags
`ifndef ASCII_RX_CONSTS_VH
`define ASCII_RX_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFF_CTRL 10'h000
`define OFF_LEN 10'h004
`define OFF_TERM 10'h008
`define OFF_FCTO 10'h00c
`define OFF_ICTO 10'h010
`define OFF_STATUS 10'h014
`define OFF_IRQ_STAT 10'h018
`define OFF_IRQ_MASK 10'h01c
`define OFF_BUF_BASE 10'h100
`define OFF_BUF_LAST 10'h200

// ****************************************
// control fields
// ****************************************
`define CTRL_EN 0
`define CTRL_VAR 1
`define CTRL_TERM2 2
`define CTRL_SWAP 3

// ****************************************
// status / interrupt fields
// ****************************************
`define ST_BUSY 0
`define ST_COMPLETE 1
`define ST_ICTO 2
`define ST_FCTO 3
`define ST_OVF 4
`define ST_ACTIVE 5
`define ST_COMMERR 6
`define ST_INVALID 7
`define ST_CANTEXEC 8
`define IRQ_W 7

// ****************************************
// reset values and limits
// ****************************************
`define RST_LEN 8'h20
`define RST_TERM 16'h000d
`define RST_TO 16'h0000
`define MAX_LEN 8'h80
`define BUF_WORDS 64

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 5
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)

`endif

/* core/ascii_string_receive.v */
// serial ascii string receiver with avalon-mm register and buffer access
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "ascii_rx_consts.vh"

module ascii_string_receive #(
   parameter MS_CYCLES = `MS_CYCLES
) (
   input wire clk_sys,
   input wire reset_n,
   input wire [9:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire [7:0] rx_data,
   input wire rx_valid,
   input wire rx_error,
   output reg busy_flag,
   output reg complete_flag,
   output reg ictimeout_flag,
   output reg fctimeout_flag,
   output reg overflow_flag,
   output reg port_active_flag,
   output reg port_comm_error_flag,
   output reg invalid_parameter_flag,
   output reg cannot_execute_flag,
   output reg irq
);

   // ****************************************
   // states
   // ****************************************
   localparam S_IDLE = 4'b0001;
   localparam S_FIRST = 4'b0010;
   localparam S_RECV = 4'b0100;
   localparam S_DONE = 4'b1000;

   // ****************************************
   // software registers and bus slave
   // ****************************************
   reg [3:0] ctrl_q;
   reg [7:0] len_q;
   reg [15:0] term_q;
   reg [15:0] fcto_q;
   reg [15:0] icto_q;
   reg [`IRQ_W-1:0] irq_stat_q;
   reg [`IRQ_W-1:0] irq_mask_q;
   reg [15:0] mem [0:`BUF_WORDS-1];
   reg [15:0] count_word_q;
   reg [31:0] rdata_d;

   wire bus_req = avs_read | avs_write;
   wire bus_take = bus_req & ~avs_waitrequest;
   wire [7:0] buf_idx = avs_address[9:2] - 8'h40;
   wire in_buf = (avs_address >= `OFF_BUF_BASE) && (avs_address <= `OFF_BUF_LAST);
   wire [5:0] mem_rd_idx = buf_idx[5:0] - 6'h01;
   wire wr_irq_stat = bus_take & avs_write & (avs_address == `OFF_IRQ_STAT);

   wire [8:0] status_w = {cannot_execute_flag, invalid_parameter_flag, port_comm_error_flag,
                          port_active_flag, overflow_flag, fctimeout_flag, ictimeout_flag,
                          complete_flag, busy_flag};

   always @* begin
      rdata_d = 32'h0000_0000;
      if (in_buf) begin
         if (buf_idx == 8'h00) begin
            rdata_d = {16'h0000, count_word_q};
         end else begin
            rdata_d = {16'h0000, mem[mem_rd_idx]};
         end
      end else begin
         case (avs_address)
            `OFF_CTRL: rdata_d = {28'h0000000, ctrl_q};
            `OFF_LEN: rdata_d = {24'h000000, len_q};
            `OFF_TERM: rdata_d = {16'h0000, term_q};
            `OFF_FCTO: rdata_d = {16'h0000, fcto_q};
            `OFF_ICTO: rdata_d = {16'h0000, icto_q};
            `OFF_STATUS: rdata_d = {23'h000000, status_w};
            `OFF_IRQ_STAT: rdata_d = {25'h0000000, irq_stat_q};
            `OFF_IRQ_MASK: rdata_d = {25'h0000000, irq_mask_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // one wait cycle per access, write lands when waitrequest is seen low
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         ctrl_q <= 4'h0;
         len_q <= `RST_LEN;
         term_q <= `RST_TERM;
         fcto_q <= `RST_TO;
         icto_q <= `RST_TO;
         irq_mask_q <= 7'h00;
      end else begin
         if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= rdata_d;
         end else begin
            avs_waitrequest <= 1'b1;
         end
         if (bus_take && avs_write) begin
            case (avs_address)
               `OFF_CTRL: ctrl_q <= avs_writedata[3:0];
               `OFF_LEN: len_q <= avs_writedata[7:0];
               `OFF_TERM: term_q <= avs_writedata[15:0];
               `OFF_FCTO: fcto_q <= avs_writedata[15:0];
               `OFF_ICTO: icto_q <= avs_writedata[15:0];
               `OFF_IRQ_MASK: irq_mask_q <= avs_writedata[`IRQ_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // ****************************************
   // millisecond base, restarted on each character
   // ****************************************
   reg [31:0] tick_cnt_q;
   reg [15:0] ms_cnt_q;
   reg en_prev_q;
   wire en = ctrl_q[`CTRL_EN];
   wire en_rise = en & ~en_prev_q;
   wire restart_time = en_rise | rx_valid;
   wire ms_tick = (tick_cnt_q == MS_CYCLES - 1);

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_q <= 32'h0000_0000;
         ms_cnt_q <= 16'h0000;
         en_prev_q <= 1'b0;
      end else begin
         en_prev_q <= en;
         if (restart_time) begin
            tick_cnt_q <= 32'h0000_0000;
            ms_cnt_q <= 16'h0000;
         end else if (ms_tick) begin
            tick_cnt_q <= 32'h0000_0000;
            if (ms_cnt_q != 16'hffff) begin
               ms_cnt_q <= ms_cnt_q + 16'h0001;
            end
         end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
         end
      end
   end

   // ****************************************
   // string reception
   // ****************************************
   reg [3:0] state_q;
   reg [7:0] count_q;
   reg [7:0] last_q;
   wire var_mode = ctrl_q[`CTRL_VAR];
   wire two_term = ctrl_q[`CTRL_TERM2];
   wire bad_cfg = (len_q == 8'h00) || (len_q > `MAX_LEN);
   // zero setting never expires
   wire fc_expired = (fcto_q != 16'h0000) && (ms_cnt_q > fcto_q);
   wire ic_expired = (icto_q != 16'h0000) && (ms_cnt_q > icto_q);
   // the first byte of a two-byte terminator is stored, then counted back out
   wire term_hit = two_term ? (count_q != 8'h00 && last_q == term_q[7:0] &&
                               rx_data == term_q[15:8])
                            : (rx_data == term_q[7:0]);
   wire [7:0] count_inc = count_q + 8'h01;
   wire store = rx_valid & (state_q == S_FIRST || state_q == S_RECV);
   wire store_byte = store & ~(var_mode & term_hit) & ~(var_mode & count_q == len_q);
   wire [5:0] widx = count_q[6:1];
   wire hi_lane = count_q[0] ^ ctrl_q[`CTRL_SWAP];

   // a timed-out string leaves the count word untouched; bytes received before the timeout are still written to memory
   always @(posedge clk_sys) begin
      if (store_byte) begin
         if (hi_lane) begin
            mem[widx][15:8] <= rx_data;
         end else begin
            mem[widx][7:0] <= rx_data;
         end
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= S_IDLE;
         count_q <= 8'h00;
         last_q <= 8'h00;
         count_word_q <= 16'h0000;
         busy_flag <= 1'b0;
         complete_flag <= 1'b0;
         ictimeout_flag <= 1'b0;
         fctimeout_flag <= 1'b0;
         overflow_flag <= 1'b0;
         port_active_flag <= 1'b0;
         port_comm_error_flag <= 1'b0;
         invalid_parameter_flag <= 1'b0;
         cannot_execute_flag <= 1'b0;
      end else if (!en) begin
         state_q <= S_IDLE;
         busy_flag <= 1'b0;
         complete_flag <= 1'b0;
         ictimeout_flag <= 1'b0;
         fctimeout_flag <= 1'b0;
         overflow_flag <= 1'b0;
         port_active_flag <= 1'b0;
         port_comm_error_flag <= 1'b0;
         invalid_parameter_flag <= 1'b0;
         cannot_execute_flag <= 1'b0;
      end else begin
         port_active_flag <= rx_valid | busy_flag;
         if (rx_error) begin
            port_comm_error_flag <= 1'b1;
         end
         if (store) begin
            last_q <= rx_data;
         end
         case (state_q)
            S_IDLE: begin
               count_q <= 8'h00;
               last_q <= 8'h00;
               if (en_rise) begin
                  if (bad_cfg) begin
                     invalid_parameter_flag <= 1'b1;
                     cannot_execute_flag <= 1'b1;
                     state_q <= S_DONE;
                  end else begin
                     state_q <= S_FIRST;
                  end
               end
            end
            S_FIRST, S_RECV: begin
               if (rx_valid) begin
                  busy_flag <= 1'b1;
                  state_q <= S_RECV;
                  if (!var_mode) begin
                     count_q <= count_inc;
                     if (count_inc == len_q) begin
                        complete_flag <= 1'b1;
                        count_word_q <= {8'h00, count_inc};
                        busy_flag <= 1'b0;
                        state_q <= S_DONE;
                     end
                  end else if (term_hit) begin
                     complete_flag <= 1'b1;
                     busy_flag <= 1'b0;
                     state_q <= S_DONE;
                     if (two_term) begin
                        count_q <= count_q - 8'h01;
                        count_word_q <= {8'h00, count_q - 8'h01};
                     end else begin
                        count_word_q <= {8'h00, count_q};
                     end
                  end else if (count_q == len_q) begin
                     overflow_flag <= 1'b1;
                     count_word_q <= {8'h00, count_q};
                     busy_flag <= 1'b0;
                     state_q <= S_DONE;
                  end else begin
                     count_q <= count_inc;
                  end
               end else if (state_q == S_FIRST && fc_expired) begin
                  fctimeout_flag <= 1'b1;
                  state_q <= S_DONE;
               end else if (state_q == S_RECV && ic_expired) begin
                  ictimeout_flag <= 1'b1;
                  busy_flag <= 1'b0;
                  state_q <= S_DONE;
               end
            end
            S_DONE: begin
               busy_flag <= 1'b0;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ****************************************
   // interrupts: rising edges of event flags, write one to clear
   // ****************************************
   reg [`IRQ_W-1:0] ev_prev_q;
   wire [`IRQ_W-1:0] ev_now = {invalid_parameter_flag, port_comm_error_flag,
                               overflow_flag, fctimeout_flag, ictimeout_flag,
                               complete_flag, cannot_execute_flag};
   wire [`IRQ_W-1:0] ev_set = ev_now & ~ev_prev_q;
   wire [`IRQ_W-1:0] clr_bits = wr_irq_stat ? avs_writedata[`IRQ_W-1:0] : 7'h00;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ev_prev_q <= 7'h00;
         irq_stat_q <= 7'h00;
         irq <= 1'b0;
      end else begin
         ev_prev_q <= ev_now;
         // a set in the clearing cycle survives
         irq_stat_q <= (irq_stat_q & ~clr_bits) | ev_set;
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

endmodule // ascii_string_receive

/* tb/rx_props.sv */
// port assertions for the ascii string receiver
`timescale 1ns/1ps
module rx_props #(
   parameter MS_CYCLES = 10
) (
   input wire clk_sys,
   input wire reset_n,
   input wire [9:0] avs_address,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire avs_waitrequest,
   input wire rx_valid,
   input wire rx_error,
   input wire busy_flag,
   input wire complete_flag,
   input wire ictimeout_flag,
   input wire fctimeout_flag,
   input wire port_active_flag,
   input wire port_comm_error_flag,
   input wire invalid_parameter_flag,
   input wire cannot_execute_flag
);
   // ****
   // properties
   // ****
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // enable cleared by an accepted control write
   wire dis = avs_write && !avs_waitrequest && avs_address == 10'h000 && !avs_writedata[0];
   property p_wait_one;
      $fell(avs_waitrequest) |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest low too long");
   property p_busy_cause;
      $rose(busy_flag) |-> $past(rx_valid);
   endproperty
   a_busy_cause: assert property (p_busy_cause)
      else $error("busy without character");
   property p_active;
      rx_valid |=> port_active_flag;
   endproperty
   a_active: assert property (p_active)
      else $error("port active missing");
   property p_comm_err;
      rx_error |-> ##[1:2] port_comm_error_flag;
   endproperty
   a_comm_err: assert property (p_comm_err)
      else $error("comm error flag missing");
   property p_complete_clear;
      dis |-> ##[1:2] !complete_flag;
   endproperty
   a_complete_clear: assert property (p_complete_clear)
      else $error("complete kept after disable");
   property p_to_clear;
      dis |-> ##[1:2] !ictimeout_flag && !fctimeout_flag;
   endproperty
   a_to_clear: assert property (p_to_clear)
      else $error("timeout kept after disable");
   property p_complete_stays;
      complete_flag && !dis && !$past(dis) |=> complete_flag;
   endproperty
   a_complete_stays: assert property (p_complete_stays)
      else $error("complete dropped while enabled");
   property p_invalid;
      $rose(invalid_parameter_flag) |-> ##[0:1] cannot_execute_flag;
   endproperty
   a_invalid: assert property (p_invalid)
      else $error("cannot execute missing");
endmodule // rx_props
bind ascii_string_receive rx_props #(.MS_CYCLES(MS_CYCLES)) u_props (.clk_sys, .reset_n,
   .avs_address, .avs_write, .avs_writedata, .avs_waitrequest, .rx_valid, .rx_error,
   .busy_flag, .complete_flag, .ictimeout_flag, .fctimeout_flag, .port_active_flag,
   .port_comm_error_flag, .invalid_parameter_flag, .cannot_execute_flag);

/* tb/rx_sender.sv */
// behavioural serial sender standing in for a scanner or a scale
`timescale 1ns/1ps
module rx_sender (
   input wire clk_sys,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_error
);
   // ****
   // character pulses
   // ****
   initial begin
      rx_data = 8'h55;
      rx_valid = 1'b0;
      rx_error = 1'b0;
   end
   // data shows the inverse between characters so stale bytes never look valid
   task automatic put(input logic [7:0] b, input int gap);
      if (gap > 0) begin
         rx_valid <= 1'b0;
         rx_data <= ~rx_data;
         repeat (gap) @(posedge clk_sys);
      end
      rx_data <= b;
      rx_valid <= 1'b1;
      @(posedge clk_sys);
   endtask
   task automatic idle();
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
   endtask
   task automatic term(input logic [15:0] tc, input logic two);
      put(tc[7:0], 0);
      if (two)
         put(tc[15:8], 0);
      idle();
   endtask
   task automatic err();
      rx_error <= 1'b1;
      @(posedge clk_sys);
      rx_error <= 1'b0;
   endtask
endmodule // rx_sender

/* tb/tb.sv */
// self-checking bench for the ascii string receiver
`timescale 1ns/1ps
`include "ascii_rx_consts.vh"
module tb;
   // ****
   // harness
   // ****
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] rd, old, avs_readdata;
   logic avs_waitrequest, busy_flag, complete_flag, ictimeout_flag, fctimeout_flag;
   logic overflow_flag, port_active_flag, port_comm_error_flag, invalid_parameter_flag;
   logic cannot_execute_flag, irq, rx_valid, rx_error;
   logic [7:0] rx_data;
   logic [7:0] q[$];
   int bad_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #2.5 clk_sys = ~clk_sys;
   // a short millisecond keeps timeout runs brief
   ascii_string_receive #(.MS_CYCLES(10)) dut (.clk_sys, .reset_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_data, .rx_valid,
      .rx_error, .busy_flag, .complete_flag, .ictimeout_flag, .fctimeout_flag, .overflow_flag,
      .port_active_flag, .port_comm_error_flag, .invalid_parameter_flag, .cannot_execute_flag,
      .irq);
   rx_sender snd (.clk_sys, .rx_data, .rx_valid, .rx_error);
   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic chk_word(input logic [31:0] got, input logic [31:0] e);
      samples_checked++;
      if (got !== e) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask
   task automatic chk_flag(input logic got, input logic e);
      chk_word({31'h0, got}, {31'h0, e});
   endtask
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      @(posedge clk_sys);
      // no local limit: only the cycle ceiling may end this wait
      while (avs_waitrequest !== 1'b0)
         @(posedge clk_sys);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk_word(rd, e);
   endtask
   task automatic off();
      bus(1'b1, `OFF_CTRL, 32'h0);
      repeat (2) @(posedge clk_sys);
   endtask
   // printable bytes only, so no byte can be taken for the terminator
   task automatic send(input int n, input int gap);
      q.delete();
      // receiver arms one edge after the enable lands; an earlier byte is dropped
      @(posedge clk_sys);
      for (int i = 0; i < n; i++) begin
         q.push_back(8'h20 + 8'($urandom % 94));
         snd.put(q[i], gap);
         if (i == 1 && n > 2)
            chk_flag(busy_flag & port_active_flag, 1'b1);
      end
   endtask
   task automatic expect_words(input logic swap);
      logic [15:0] w;
      rd_chk(`OFF_BUF_BASE, 32'(q.size()));
      for (int k = 0; k < q.size() / 2; k++) begin
         w = swap ? {q[2*k], q[2*k+1]} : {q[2*k+1], q[2*k]};
         rd_chk(`OFF_BUF_BASE + 10'h4 + 10'(4 * k), {16'h0, w});
      end
   endtask
   // ****
   // scenarios
   // ****
   initial begin
      rd = $urandom(32'hf2c5);
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd_chk(`OFF_LEN, 32'h20);
      rd_chk(10'h3fc, 32'h0);
      bus(1'b1, `OFF_IRQ_MASK, 32'h7f);
      bus(1'b1, `OFF_LEN, 32'h80);
      bus(1'b1, `OFF_CTRL, 32'h1);
      send(128, 0);
      snd.idle();
      repeat (2) @(posedge clk_sys);
      chk_flag(complete_flag, 1'b1);
      chk_flag(busy_flag, 1'b0);
      expect_words(1'b0);
      snd.put(8'h41, 1);
      snd.idle();
      rd_chk(`OFF_BUF_BASE, 32'h80);
      chk_flag(irq, 1'b1);
      rd_chk(`OFF_IRQ_STAT, 32'h2);
      bus(1'b1, `OFF_IRQ_STAT, 32'h7f);
      off();
      chk_flag(complete_flag | irq, 1'b0);
      bus(1'b1, `OFF_LEN, 32'h10);
      bus(1'b1, `OFF_TERM, 32'h0a0d);
      bus(1'b1, `OFF_CTRL, 32'hf);
      send(6, 25);
      snd.term(16'h0a0d, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk_flag(complete_flag, 1'b1);
      chk_flag(ictimeout_flag | fctimeout_flag, 1'b0);
      expect_words(1'b1);
      off();
      bus(1'b1, `OFF_LEN, 32'h2);
      bus(1'b1, `OFF_CTRL, 32'h3);
      send(3, 0);
      snd.idle();
      repeat (2) @(posedge clk_sys);
      chk_flag(overflow_flag, 1'b1);
      chk_flag(complete_flag, 1'b0);
      off();
      bus(1'b1, `OFF_IRQ_MASK, 32'h0);
      bus(1'b1, `OFF_FCTO, 32'h2);
      bus(1'b1, `OFF_CTRL, 32'h1);
      repeat (40) @(posedge clk_sys);
      chk_flag(fctimeout_flag, 1'b1);
      chk_flag(irq, 1'b0);
      bus(1'b1, `OFF_IRQ_MASK, 32'h8);
      repeat (2) @(posedge clk_sys);
      chk_flag(irq, 1'b1);
      bus(1'b1, `OFF_IRQ_STAT, 32'h8);
      off();
      chk_flag(fctimeout_flag | irq, 1'b0);
      bus(1'b1, `OFF_FCTO, 32'h0);
      bus(1'b1, `OFF_ICTO, 32'h1);
      bus(1'b0, `OFF_BUF_BASE, 32'h0);
      old = rd;
      bus(1'b1, `OFF_LEN, 32'h4);
      bus(1'b1, `OFF_CTRL, 32'h1);
      send(1, 0);
      snd.idle();
      repeat (25) @(posedge clk_sys);
      chk_flag(ictimeout_flag, 1'b1);
      repeat (3) snd.put(8'h42, 0);
      snd.idle();
      repeat (2) @(posedge clk_sys);
      chk_flag(complete_flag, 1'b0);
      rd_chk(`OFF_BUF_BASE, old);
      off();
      chk_flag(ictimeout_flag, 1'b0);
      bus(1'b1, `OFF_ICTO, 32'h0);
      bus(1'b1, `OFF_LEN, 32'h2);
      bus(1'b1, `OFF_CTRL, 32'h3);
      chk_flag(complete_flag, 1'b0);
      send(2, 0);
      snd.term(16'h000d, 1'b0);
      snd.err();
      repeat (2) @(posedge clk_sys);
      chk_flag(complete_flag, 1'b1);
      chk_flag(port_comm_error_flag, 1'b1);
      expect_words(1'b0);
      off();
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, `OFF_LEN, i ? 32'h81 : 32'h0);
         bus(1'b1, `OFF_CTRL, 32'h1);
         repeat (2) @(posedge clk_sys);
         chk_flag(invalid_parameter_flag & cannot_execute_flag, 1'b1);
         off();
      end
      test_done();
   end
endmodule // tb
